// *** rtl/uirq_pkg.sv ***
// uirq_pkg: register map, field positions, reset values and counts
// assumes one 10 MHz clock and a classic wishbone slave port
package uirq_pkg;
   // clock
   localparam int unsigned CLK_HZ        = 10_000_000;
   // register byte addresses
   localparam logic [7:0]  ADR_DATA      = 8'h00;
   localparam logic [7:0]  ADR_IER       = 8'h04;
   localparam logic [7:0]  ADR_IIR_FCR   = 8'h08;
   localparam logic [7:0]  ADR_MCR       = 8'h10;
   localparam logic [7:0]  ADR_LSR       = 8'h14;
   localparam logic [7:0]  ADR_DIV       = 8'h18;
   localparam logic [7:0]  ADR_LPDIV_LO  = 8'h1C;
   localparam logic [7:0]  ADR_LPDIV_HI  = 8'h20;
   // field positions
   localparam int          MCR_SIR_BIT   = 6;
   localparam int          IER_RDA_BIT   = 0;
   localparam int          IER_TRANSMIT_HOLDING_EMPTY_BIT  = 1;
   localparam int          IER_RLS_BIT   = 2;
   localparam int          IER_PTHRE_BIT = 7;
   localparam int          FCR_EN_BIT    = 0;
   localparam int          FCR_RXCLR_BIT = 1;
   localparam int          FCR_TXCLR_BIT = 2;
   localparam int          FCR_THR_LO    = 4;
   localparam int          FCR_TRG_LO    = 6;
   // values after reset
   localparam logic [7:0]  IER_RST       = 8'h00;
   localparam logic [7:0]  MCR_RST       = 8'h00;
   localparam logic [15:0] DIV_RST       = 16'h0001;
   localparam logic [15:0] LPDIV_RST     = 16'h0000;
   // bit timing in baud ticks
   localparam logic [3:0]  BIT_LAST      = 4'hF;
   localparam logic [3:0]  MID_TICK      = 4'h7;
   localparam logic [3:0]  PULSE_TICKS   = 4'h3;
   localparam logic [3:0]  STOP_IDX      = 4'h9;
   localparam int          CHAR_BITS     = 10;
   localparam int          TOUT_CHARS    = 4;
   localparam logic [9:0]  TOUT_TICKS    = 10'(TOUT_CHARS * CHAR_BITS * 16);
   // identification codes
   localparam logic [3:0]  IIR_NONE      = 4'h1;
   localparam logic [3:0]  IIR_RLS       = 4'h6;
   localparam logic [3:0]  IIR_RDA       = 4'h4;
   localparam logic [3:0]  IIR_TOUT      = 4'hC;
   localparam logic [3:0]  IIR_TRANSMIT_HOLDING_EMPTY      = 4'h2;

   typedef struct packed {
      logic rx_err;
      logic temt;
      logic transmit_holding_empty;
      logic bi;
      logic fe;
      logic pe;
      logic oe;
      logic dr;
   } uirq_lsr_t;

   typedef enum logic {RX_IDLE, RX_RUN} uirq_rx_st_t;
   typedef enum logic {TX_IDLE, TX_RUN} uirq_tx_st_t;
endpackage

// *** rtl/uirq_core.sv ***
// uirq_core: serial port with infrared pulse mode, fifos and prioritized interrupt id
// assumes classic wishbone master on clk_i; line pins are asynchronous to clk_i
//
// Contract
// (RQ1) infrared mode follows modem control bit 6, only when infrared support is built
// (RQ2) infrared mode uses the active-low infrared out and infrared in pins
// (RQ3) infrared zero bits, start included, send one pulse; one bits send none
// (RQ4) each infrared pulse lasts three baud ticks, 3/16 of a bit
// (RQ5) low on infrared input is a received pulse and decodes as zero
// (RQ6) low-power receive catches short pulses using the low-power divisor
// (RQ7) low-power divisor sets the sampling period, hence the least detectable pulse
// (RQ8) infrared mode otherwise normal but half-duplex only; a receive start and a transmit load in one cycle both proceed
// (RQ9) software waits at least 10 ms between sending and receiving in infrared
// (RQ10) line and register logic kept apart; pins synchronised before use
// (RQ11) serial clock kept within four times the bus clock
// (RQ12) new register values act within eight cycles; software waits that long
// (RQ13) interrupt out when any enabled source active; id 0001 when none
// (RQ14) line status id 0110 on overrun, parity, framing, break; cleared by status read
// (RQ15) data available id 0100 at trigger level or data present; clears below
// (RQ16) fifo mode timeout id 1100 after four idle char times with data
// (RQ17) transmit empty id 0010; cleared by id read, holding write or above threshold
// (RQ18) programmable threshold mode enabled by interrupt enable bit 7
// (RQ19) threshold from fifo control bits 5:4: empty, 2, quarter, half
// (RQ20) in threshold mode line status bit 5 shows transmit fifo full
// (RQ21) fifos off disables threshold mode; bit 5 and interrupt then show empty
// (RQ22) sixteen baud ticks per bit; receiver samples near bit middle
// (RQ23) characters are start, eight data bits, one stop, no parity
// (RQ24) id reports highest-priority source; lower ones stay pending
//
// The implementer's own choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module uirq_core
   import uirq_pkg::*;
#(
   parameter bit SIR_EN   = 1'b1,
   parameter bit PTHRE_EN = 1'b1,
   parameter int DEPTH    = 16
) (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   // wishbone slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   // serial and infrared line
   input  wire logic        ser_in_i,
   output logic             ser_out_o,
   input  wire logic        sir_in_i,
   output logic             sir_out_n_o,
   // interrupt
   output logic             intr_o
);
   localparam int         AW       = $clog2(DEPTH);
   localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

   if (DEPTH < 8 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
      $error("DEPTH must be a power of two of at least 8");
   end

   function automatic logic [AW:0] thr_map(input logic [1:0] s);
      case (s)
         2'b00:   thr_map = '0;
         2'b01:   thr_map = (AW+1)'(2);
         2'b10:   thr_map = (AW+1)'(DEPTH / 4);
         default: thr_map = (AW+1)'(DEPTH / 2);
      endcase
   endfunction

   function automatic logic [AW:0] trg_map(input logic [1:0] s);
      case (s)
         2'b00:   trg_map = (AW+1)'(1);
         2'b01:   trg_map = (AW+1)'(DEPTH / 4);
         2'b10:   trg_map = (AW+1)'(DEPTH / 2);
         default: trg_map = (AW+1)'(DEPTH - 2);
      endcase
   endfunction

   // registers
   logic [7:0]  ier_q, mcr_q, rx_sh_q;
   logic [15:0] div_q, lpdiv_q, bcnt_q, lcnt_q;
   logic        fen_q, oe_q, fe_q, bi_q, transmit_holding_empty_pend_q, transmit_holding_empty_cond_q, ack_q, intr_q;
   logic [1:0]  trg_q, thr_q, s1_q, s2_q;
   logic [31:0] dat_q;
   logic [7:0]  rx_mem [DEPTH];
   logic [7:0]  tx_mem [DEPTH];
   logic [AW:0] rx_wp_q, rx_rp_q, tx_wp_q, tx_rp_q;
   uirq_rx_st_t rx_st_q;
   uirq_tx_st_t tx_st_q;
   logic [3:0]  rx_tcnt_q, rx_bit_q, tx_tcnt_q, tx_bit_q;
   logic        rx_low_q, rx_mid_q, sout_q, sirn_q;
   logic [9:0]  tx_sh_q, tout_q;

   // bus decode
   wire        req      = cyc_i & stb_i & ~ack_q;
   wire        wr       = req & we_i & sel_i[0];
   wire        rd       = req & ~we_i;
   wire        hit_data = adr_i == ADR_DATA;
   wire        hit_ier  = adr_i == ADR_IER;
   wire        hit_iir  = adr_i == ADR_IIR_FCR;
   wire        hit_mcr  = adr_i == ADR_MCR;
   wire        hit_lsr  = adr_i == ADR_LSR;
   wire        hit_div  = adr_i == ADR_DIV;
   wire        hit_lplo = adr_i == ADR_LPDIV_LO;
   wire        hit_lphi = adr_i == ADR_LPDIV_HI;
   wire        fcr_wr   = wr & hit_iir;

   // mode and ticks
   wire        ir_on    = SIR_EN & mcr_q[MCR_SIR_BIT];                        // [RQ1]
   wire        btick    = ce_i & (bcnt_q == 16'h0000);
   wire        ltick    = ce_i & (lcnt_q == 16'h0000);
   wire        lp_on    = ir_on & (lpdiv_q != 16'h0000);                      // [RQ6]
   wire        smp_ev   = lp_on ? ltick : btick;                              // [RQ7]
   wire        rx_line  = ir_on ? s2_q[1] : s2_q[0];                          // [RQ2] [RQ5]

   // fifo levels
   wire [AW:0] rx_cnt   = rx_wp_q - rx_rp_q;
   wire [AW:0] tx_cnt   = tx_wp_q - tx_rp_q;
   wire        rx_full  = fen_q ? (rx_cnt == FULL_CNT) : (rx_cnt != '0);
   wire        tx_full  = fen_q ? (tx_cnt == FULL_CNT) : (tx_cnt != '0);
   wire        rx_empty = rx_cnt == '0;
   wire        tx_empty = tx_cnt == '0;
   wire        rx_clr   = fcr_wr & (dat_i[FCR_RXCLR_BIT] | (dat_i[FCR_EN_BIT] != fen_q));
   wire        tx_clr   = fcr_wr & (dat_i[FCR_TXCLR_BIT] | (dat_i[FCR_EN_BIT] != fen_q));

   // receiver bit decisions
   wire        rx_run   = rx_st_q == RX_RUN;
   wire        tx_run   = tx_st_q == TX_RUN;
   wire        rx_blind = ir_on & tx_run;                                     // [RQ8]
   wire        rx_start = ~rx_run & ~rx_blind & ~rx_line & (ir_on ? smp_ev : btick);
   wire        rx_end   = rx_run & btick & (rx_tcnt_q == BIT_LAST);
   wire        rx_bitv  = ir_on ? ~rx_low_q : rx_mid_q;                       // [RQ5] [RQ22]
   wire        rx_stop  = rx_end & (rx_bit_q == STOP_IDX);                    // [RQ23]
   wire        rx_push  = rx_stop & ~rx_full;
   wire        rx_ovr   = rx_stop & rx_full;
   wire        rx_pop   = rd & hit_data & ~rx_empty;

   // transmitter
   wire        tx_push  = wr & hit_data & ~tx_full;
   wire        tx_load  = ~tx_run & btick & ~tx_empty & ~(ir_on & rx_run);   // [RQ8]
   wire        tx_end   = tx_run & btick & (tx_tcnt_q == BIT_LAST) & (tx_bit_q == STOP_IDX);
   wire        pulse    = ir_on & tx_run & ~tx_sh_q[0] & (tx_tcnt_q < PULSE_TICKS); // [RQ3] [RQ4]

   // interrupt sources
   wire        prog     = PTHRE_EN & ier_q[IER_PTHRE_BIT] & fen_q;            // [RQ18] [RQ21]
   wire        transmit_holding_empty_c   = prog ? (tx_cnt <= thr_map(thr_q)) : tx_empty;       // [RQ19] [RQ21]
   wire        ls_pend  = oe_q | fe_q | bi_q;                                 // [RQ14]
   wire        rda      = fen_q ? (rx_cnt >= trg_map(trg_q)) : ~rx_empty;     // [RQ15]
   wire        to_act   = fen_q & ~rx_empty & (tout_q == TOUT_TICKS);         // [RQ16]
   wire [3:0]  iir_id   = (ier_q[IER_RLS_BIT] & ls_pend)     ? IIR_RLS  :     // [RQ24]
                          (ier_q[IER_RDA_BIT] & rda)         ? IIR_RDA  :
                          (ier_q[IER_RDA_BIT] & to_act)      ? IIR_TOUT :
                          (ier_q[IER_TRANSMIT_HOLDING_EMPTY_BIT] & transmit_holding_empty_pend_q) ? IIR_TRANSMIT_HOLDING_EMPTY : IIR_NONE; // [RQ13]
   wire        ier_transmit_holding_empty_on = wr & hit_ier & dat_i[IER_TRANSMIT_HOLDING_EMPTY_BIT] & ~ier_q[IER_TRANSMIT_HOLDING_EMPTY_BIT];
   wire        transmit_holding_empty_set = (transmit_holding_empty_c & ~transmit_holding_empty_cond_q) | (ier_transmit_holding_empty_on & transmit_holding_empty_c);
   wire        transmit_holding_empty_clr = (rd & hit_iir & (iir_id == IIR_TRANSMIT_HOLDING_EMPTY))               // [RQ17]
                          | (wr & hit_data & ~prog) | ~transmit_holding_empty_c;
   wire        lsr_rd   = rd & hit_lsr;

   uirq_lsr_t lsr_v;
   assign lsr_v.dr     = ~rx_empty;
   assign lsr_v.oe     = oe_q;
   assign lsr_v.pe     = 1'b0;
   assign lsr_v.fe     = fe_q;
   assign lsr_v.bi     = bi_q;
   assign lsr_v.transmit_holding_empty   = prog ? tx_full : tx_empty;                           // [RQ20] [RQ21]
   assign lsr_v.temt   = tx_empty & ~tx_run;
   assign lsr_v.rx_err = 1'b0;

   wire [7:0]  rbr_v = rx_empty ? 8'h00 : rx_mem[rx_rp_q[AW-1:0]];
   wire [31:0] rd_v  = hit_data ? {24'h000000, rbr_v} :
                       hit_ier  ? {24'h000000, ier_q} :
                       hit_iir  ? {24'h000000, fen_q, fen_q, 2'b00, iir_id} :
                       hit_mcr  ? {24'h000000, mcr_q} :
                       hit_lsr  ? {24'h000000, lsr_v} :
                       hit_div  ? {16'h0000, div_q} :
                       hit_lplo ? {24'h000000, lpdiv_q[7:0]} :
                       hit_lphi ? {24'h000000, lpdiv_q[15:8]} : 32'h00000000;

   // bus slave and control registers, applied at once
   always_ff @(posedge clk_i) begin                                          // [RQ12]
      if (rst_i) begin
         ack_q   <= 1'b0;
         dat_q   <= 32'h00000000;
         ier_q   <= IER_RST;
         mcr_q   <= MCR_RST;
         div_q   <= DIV_RST;
         lpdiv_q <= LPDIV_RST;
         fen_q   <= 1'b0;
         trg_q   <= 2'b00;
         thr_q   <= 2'b00;
      end else if (ce_i) begin
         ack_q <= req;
         dat_q <= rd ? rd_v : 32'h00000000;
         if (wr & hit_ier)  ier_q <= dat_i[7:0];
         if (wr & hit_mcr)  mcr_q <= dat_i[7:0];
         if (wr & hit_lplo) lpdiv_q[7:0]  <= dat_i[7:0];
         if (wr & hit_lphi) lpdiv_q[15:8] <= dat_i[7:0];
         if (wr & hit_div)  div_q[7:0]    <= dat_i[7:0];
         if (req & we_i & hit_div & sel_i[1]) div_q[15:8] <= dat_i[15:8];
         if (fcr_wr) begin
            fen_q <= dat_i[FCR_EN_BIT];
            trg_q <= dat_i[FCR_TRG_LO +: 2];
            thr_q <= dat_i[FCR_THR_LO +: 2];
         end
      end
   end

   // line status flags, interrupt state; set wins over clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         oe_q        <= 1'b0;
         fe_q        <= 1'b0;
         bi_q        <= 1'b0;
         transmit_holding_empty_pend_q <= 1'b0;
         transmit_holding_empty_cond_q <= 1'b1;
         tout_q      <= 10'h000;
         intr_q      <= 1'b0;
      end else if (ce_i) begin
         oe_q        <= rx_ovr | (oe_q & ~lsr_rd);                            // [RQ14]
         fe_q        <= (rx_stop & ~rx_bitv) | (fe_q & ~lsr_rd);
         bi_q        <= (rx_stop & ~rx_bitv & (rx_sh_q == 8'h00)) | (bi_q & ~lsr_rd);
         transmit_holding_empty_pend_q <= transmit_holding_empty_set | (transmit_holding_empty_pend_q & ~transmit_holding_empty_clr);                // [RQ17]
         transmit_holding_empty_cond_q <= transmit_holding_empty_c;
         if (rx_push | rx_pop | rx_empty | rx_clr) tout_q <= 10'h000;         // [RQ16]
         else if (btick & (tout_q != TOUT_TICKS)) tout_q <= tout_q + 10'h001;
         intr_q      <= iir_id != IIR_NONE;                                   // [RQ13]
      end
   end

   // baud and low-power tick dividers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bcnt_q <= 16'h0000;
         lcnt_q <= 16'h0000;
      end else if (ce_i) begin
         bcnt_q <= (bcnt_q == 16'h0000) ? ((div_q == 16'h0000) ? 16'h0000 : div_q - 16'h0001)
                                        : bcnt_q - 16'h0001;
         lcnt_q <= (lcnt_q == 16'h0000) ? ((lpdiv_q == 16'h0000) ? 16'h0000
                                                                 : lpdiv_q - 16'h0001)
                                        : lcnt_q - 16'h0001;                  // [RQ7]
      end
   end

   // pin synchronisers: bit 1 infrared in, bit 0 serial in
   always_ff @(posedge clk_i) begin                                          // [RQ10]
      if (rst_i) begin
         s1_q <= 2'b11;
         s2_q <= 2'b11;
      end else if (ce_i) begin
         s1_q <= {sir_in_i, ser_in_i};
         s2_q <= s1_q;
      end
   end

   // receiver
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_st_q   <= RX_IDLE;
         rx_tcnt_q <= 4'h0;
         rx_bit_q  <= 4'h0;
         rx_sh_q   <= 8'h00;
         rx_low_q  <= 1'b0;
         rx_mid_q  <= 1'b1;
      end else if (ce_i) begin
         case (rx_st_q)
            RX_IDLE: begin
               if (rx_start) begin
                  rx_st_q   <= RX_RUN;
                  rx_tcnt_q <= 4'h0;
                  rx_bit_q  <= 4'h0;
                  rx_low_q  <= 1'b1;
               end
            end
            RX_RUN: begin
               if (rx_end) rx_low_q <= smp_ev & ~rx_line;
               else if (smp_ev & ~rx_line) rx_low_q <= 1'b1;                  // [RQ5] [RQ6]
               if (btick) begin
                  rx_tcnt_q <= rx_tcnt_q + 4'h1;                              // [RQ22]
                  if (rx_tcnt_q == MID_TICK) rx_mid_q <= rx_line;
               end
               if (rx_end) begin
                  rx_bit_q <= rx_bit_q + 4'h1;
                  if (rx_bit_q == 4'h0 && rx_bitv) rx_st_q <= RX_IDLE;
                  else if (rx_bit_q == STOP_IDX) rx_st_q <= RX_IDLE;
                  else rx_sh_q <= {rx_bitv, rx_sh_q[7:1]};                    // [RQ23]
               end
            end
            default: rx_st_q <= RX_IDLE;
         endcase
      end
   end

   // receive fifo
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_wp_q <= '0;
         rx_rp_q <= '0;
      end else if (ce_i) begin
         if (rx_clr) begin
            rx_wp_q <= '0;
            rx_rp_q <= '0;
         end else begin
            if (rx_push) begin
               rx_mem[rx_wp_q[AW-1:0]] <= rx_sh_q;
               rx_wp_q <= rx_wp_q + 1'b1;
            end
            if (rx_pop) rx_rp_q <= rx_rp_q + 1'b1;                            // [RQ15]
         end
      end
   end

   // transmit fifo
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_wp_q <= '0;
         tx_rp_q <= '0;
      end else if (ce_i) begin
         if (tx_clr) begin
            tx_wp_q <= '0;
            tx_rp_q <= '0;
         end else begin
            if (tx_push) begin
               tx_mem[tx_wp_q[AW-1:0]] <= dat_i[7:0];
               tx_wp_q <= tx_wp_q + 1'b1;
            end
            if (tx_load) tx_rp_q <= tx_rp_q + 1'b1;
         end
      end
   end

   // transmitter, fixed eight data bits and one stop bit
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_st_q   <= TX_IDLE;
         tx_tcnt_q <= 4'h0;
         tx_bit_q  <= 4'h0;
         tx_sh_q   <= 10'h3FF;
      end else if (ce_i) begin
         case (tx_st_q)
            TX_IDLE: begin
               if (tx_load) begin
                  tx_st_q   <= TX_RUN;
                  tx_tcnt_q <= 4'h0;
                  tx_bit_q  <= 4'h0;
                  tx_sh_q   <= {1'b1, tx_mem[tx_rp_q[AW-1:0]], 1'b0};        // [RQ23]
               end
            end
            TX_RUN: begin
               if (btick) begin
                  tx_tcnt_q <= tx_tcnt_q + 4'h1;                              // [RQ22]
                  if (tx_tcnt_q == BIT_LAST) begin
                     tx_bit_q <= tx_bit_q + 4'h1;
                     tx_sh_q  <= {1'b1, tx_sh_q[9:1]};
                  end
               end
               if (tx_end) tx_st_q <= TX_IDLE;
            end
            default: tx_st_q <= TX_IDLE;
         endcase
      end
   end

   // line outputs
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sout_q <= 1'b1;
         sirn_q <= 1'b1;
      end else if (ce_i) begin
         sout_q <= ir_on | ~tx_run | tx_sh_q[0];                              // [RQ2]
         sirn_q <= ~pulse;                                                    // [RQ3] [RQ4]
      end
   end

   assign dat_o       = dat_q;
   assign ack_o       = ack_q;
   assign ser_out_o   = sout_q;
   assign sir_out_n_o = sirn_q;
   assign intr_o      = intr_q;

   // checks
   property p_ir_off_quiet;
      @(posedge clk_i) disable iff (rst_i) (ce_i & ~ir_on) |=> sir_out_n_o;
   endproperty
   a_ir_off_quiet: assert property (p_ir_off_quiet) else $error("pulse while infrared off"); // [RQ1]

   property p_ser_idle_ir;
      @(posedge clk_i) disable iff (rst_i) (ce_i & ir_on) |=> ser_out_o;
   endproperty
   a_ser_idle_ir: assert property (p_ser_idle_ir) else $error("serial out active in infrared"); // [RQ2]

   property p_pulse_cause;
      @(posedge clk_i) disable iff (rst_i)
         $fell(sir_out_n_o) |-> $past(tx_tcnt_q) == 4'h0 && !$past(tx_sh_q[0]);
   endproperty
   a_pulse_cause: assert property (p_pulse_cause) else $error("pulse not at zero bit start"); // [RQ3]

   property p_pulse_width;
      @(posedge clk_i) disable iff (rst_i) !sir_out_n_o |-> $past(tx_tcnt_q) < PULSE_TICKS;
   endproperty
   a_pulse_width: assert property (p_pulse_width) else $error("pulse too long"); // [RQ4]

   property p_half_duplex;
      @(posedge clk_i) disable iff (rst_i) (ir_on & rx_run & ~tx_run) |=> ~tx_run;
   endproperty
   a_half_duplex: assert property (p_half_duplex) else $error("send during receive"); // [RQ8]

   property p_intr_follows;
      @(posedge clk_i) disable iff (rst_i)
         (ce_i && iir_id == IIR_NONE) ##1 ce_i |-> ##1 !intr_o || $past(iir_id) != IIR_NONE;
   endproperty
   a_intr_follows: assert property (p_intr_follows) else $error("interrupt with none pending"); // [RQ13]

   property p_ls_clear;
      @(posedge clk_i) disable iff (rst_i) (ce_i & lsr_rd & ~rx_stop) |=> !oe_q && !fe_q;
   endproperty
   a_ls_clear: assert property (p_ls_clear) else $error("status read did not clear"); // [RQ14]

   property p_priority;
      @(posedge clk_i) disable iff (rst_i) (ier_q[IER_RLS_BIT] & ls_pend) |-> iir_id == IIR_RLS;
   endproperty
   a_priority: assert property (p_priority) else $error("wrong id priority"); // [RQ24]

   property p_transmit_holding_empty_write;
      @(posedge clk_i) disable iff (rst_i)
         (ce_i & wr & hit_data & ~prog & ~transmit_holding_empty_set) |=> !transmit_holding_empty_pend_q;
   endproperty
   a_transmit_holding_empty_write: assert property (p_transmit_holding_empty_write) else $error("holding write kept empty flag"); // [RQ17]

   property p_lsr5_full;
      @(posedge clk_i) disable iff (rst_i) (prog & tx_full) |-> lsr_v.transmit_holding_empty;
   endproperty
   a_lsr5_full: assert property (p_lsr5_full) else $error("bit 5 not full indication"); // [RQ20]

   property p_tout_fifo;
      @(posedge clk_i) disable iff (rst_i) to_act |-> fen_q && !rx_empty;
   endproperty
   a_tout_fifo: assert property (p_tout_fifo) else $error("timeout outside fifo mode"); // [RQ16]

   c_ir_pulse: cover property (@(posedge clk_i) disable iff (rst_i) $fell(sir_out_n_o));
   c_rx_push:  cover property (@(posedge clk_i) disable iff (rst_i) rx_push);
   c_transmit_holding_empty_id:  cover property (@(posedge clk_i) disable iff (rst_i) iir_id == IIR_TRANSMIT_HOLDING_EMPTY);
endmodule
`default_nettype wire

// *** bench/uirq_remote.sv ***
// uirq_remote: far-side infrared transceiver model
// assumes divisor 1, one baud tick per clk_i
`timescale 1ns/1ns
`default_nettype none
module uirq_remote (
   // clock
   input  wire logic       clk_i,
   // infrared line
   input  wire logic       sir_out_n_i,
   output var  logic       sir_in_o,
   // decoded characters
   output var  logic [7:0] got_o,
   output var  logic [7:0] cnt_o,
   output var  logic [7:0] bad_o
);
   int lo;
   initial begin
      sir_in_o = 1'b1;
      got_o = 8'h00;
      cnt_o = 8'h00;
      bad_o = 8'h00;
   end
   // zero bit is exactly three low ticks, lsb first
   always begin
      @(negedge sir_out_n_i);
      for (int i = 0; i < 10; i++) begin
         lo = 0;
         repeat (16) begin
            @(posedge clk_i);
            lo += (sir_out_n_i === 1'b0);
         end
         if (lo != 0 && lo != 3) bad_o <= bad_o + 8'h01;
         if (i > 0 && i < 9) got_o <= {lo == 0, got_o[7:1]};
      end
      cnt_o <= cnt_o + 8'h01;
   end
   // send one 8n1 character, low pulse marks zero
   task automatic send(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         for (int j = 0; j < 16; j++) begin
            @(posedge clk_i);
            sir_in_o <= f[i] | (j > 2);
         end
      end
   endtask
endmodule
`default_nettype wire

// *** bench/tb_uart_infrared_and_interrupt_logic.sv ***
// tb: register, infrared and interrupt checks of uirq_core
// assumes uirq_remote on the infrared pins, divisor 1
`timescale 1ns/1ns
`default_nettype none
module tb_uart_infrared_and_interrupt_logic
   import uirq_pkg::*;
;
   logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, ce_i = 1'b1;
   logic [7:0]  adr_i = 8'h00, got, cnt, bad, c;
   logic [3:0]  sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0, dat_o, rd, seed = 32'hC3EB;
   logic        ack_o, ser_out_o, sir_in_i, sir_out_n_o, intr_o;
   int          n_errors = 0, n_tests = 0;
   logic [7:0]  q[$];
   always #50 clk_i = ~clk_i; // one clock for line and bus
   uirq_core dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .ser_in_i(1'b1), .ser_out_o(ser_out_o), .sir_in_i(sir_in_i),
      .sir_out_n_o(sir_out_n_o), .intr_o(intr_o));
   uirq_remote rem_u (.clk_i(clk_i), .sir_out_n_i(sir_out_n_o), .sir_in_o(sir_in_i),
      .got_o(got), .cnt_o(cnt), .bad_o(bad));
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      sel_i <= 4'hF;
      dat_i <= {24'h0, d};
      do @(posedge clk_i); while (ack_o !== 1'b1);
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
         n_errors++;
      end
   endtask
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic results;
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      repeat (8000) @(posedge clk_i);
      n_errors++;
      results;
   end
   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      wb(1'b0, ADR_IER, 8'h00);
      chk(rd, {24'h0, IER_RST});
      ce_i <= 1'b0;
      fork
         wb(1'b0, ADR_MCR, 8'h00);
         begin
            repeat (4) @(posedge clk_i);
            chk({31'h0, ack_o}, 32'h0);
            ce_i <= 1'b1;
         end
      join
      chk(rd, {24'h0, MCR_RST});
      wb(1'b0, ADR_IIR_FCR, 8'h00);
      chk(rd, {28'h0, IIR_NONE});
      wb(1'b0, 8'h30, 8'h00);
      chk(rd, 32'h0);
      $display("test reset done");
      wb(1'b1, ADR_MCR, 8'h40);
      repeat (8) @(posedge clk_i);
      repeat (2) begin
         seed = lfsr(seed);
         q.push_back(seed[7:0]);
         wb(1'b1, ADR_DATA, seed[7:0]);
         c = cnt;
         while (cnt === c) begin
            @(posedge clk_i);
            chk({31'h0, ser_out_o}, 32'h1);
         end
         chk(got, q.pop_front());
      end
      chk(bad, 8'h00);
      $display("test infrared send done");
      repeat (32) @(posedge clk_i); // gap shortened for run time
      seed = lfsr(seed);
      rem_u.send(seed[7:0]);
      repeat (40) @(posedge clk_i);
      wb(1'b0, ADR_LSR, 8'h00);
      chk(rd[0], 1);
      wb(1'b1, ADR_IER, 8'h03);
      chk(intr_o, 1);
      wb(1'b0, ADR_IIR_FCR, 8'h00);
      chk(rd, {28'h0, IIR_RDA});
      wb(1'b0, ADR_DATA, 8'h00);
      chk(rd, {24'h0, seed[7:0]});
      wb(1'b0, ADR_IIR_FCR, 8'h00);
      chk(rd, {28'h0, IIR_TRANSMIT_HOLDING_EMPTY});
      wb(1'b0, ADR_IIR_FCR, 8'h00);
      chk(rd, {28'h0, IIR_NONE});
      chk(intr_o, 0);
      wb(1'b1, ADR_IIR_FCR, 8'h01);
      wb(1'b1, ADR_IER, 8'h80);
      wb(1'b1, ADR_IER, 8'h82);
      wb(1'b0, ADR_IIR_FCR, 8'h00);
      chk(rd, {24'h0, 4'hC, IIR_TRANSMIT_HOLDING_EMPTY});
      wb(1'b0, ADR_LSR, 8'h00);
      chk(rd[5], 0);
      wb(1'b1, ADR_IIR_FCR, 8'h00);
      wb(1'b0, ADR_LSR, 8'h00);
      chk(rd[5], 1);
      $display("test interrupts done");
      wb(1'b1, ADR_LPDIV_LO, 8'h02);
      wb(1'b0, ADR_LPDIV_LO, 8'h00);
      chk(rd, 32'h00000002);
      repeat (32) @(posedge clk_i);
      seed = lfsr(seed);
      q.push_back(seed[7:0]);
      rem_u.send(seed[7:0]);
      repeat (40) @(posedge clk_i);
      wb(1'b0, ADR_DATA, 8'h00);
      chk(rd, {24'h0, q.pop_front()});
      $display("test low power done");
      results;
   end
endmodule
`default_nettype wire
